// File: pdg_defs.svh
// register offsets, reset values, field positions and ranges of the deviation guard
// assumes a 40 MHz system clock and APB with 32-bit data and 8-bit byte addresses
`ifndef PDG_DEFS_SVH
`define PDG_DEFS_SVH

`define PDG_OFF_CTRL       8'h00
`define PDG_OFF_OVF_LIM    8'h04
`define PDG_OFF_SON_LIM    8'h08
`define PDG_OFF_WARN_PCT   8'h0c
`define PDG_OFF_SON_PCT    8'h10
`define PDG_OFF_SON_SPD    8'h14
`define PDG_OFF_TRQ_MAX    8'h18
`define PDG_OFF_STATUS     8'h1c
`define PDG_OFF_MASK       8'h20
`define PDG_OFF_DEV        8'h24
`define PDG_OFF_STATE      8'h28

`define PDG_LIM_MIN        30'h0000001
`define PDG_LIM_MAX        30'h3fffffff
`define PDG_LIM_RST        30'h2800000
`define PDG_PCT_MIN        7'h0a
`define PDG_PCT_MAX        7'h64
`define PDG_PCT_RST        7'h64
`define PDG_PCT_SCALE      7'h64
`define PDG_SPD_MAX        14'h2710
`define PDG_SPD_RST        14'h2710
`define PDG_TRQ_RST        16'h7fff

`define PDG_STS_W          5
`define PDG_STS_OVF        0
`define PDG_STS_SON        1
`define PDG_STS_SON_SPD    2
`define PDG_STS_WARN       3
`define PDG_STS_SON_WARN   4

`endif

// File: pdg_pkg.sv
// types shared by the deviation guard
// assumes pdg_defs.svh for numeric constants
package pdg_pkg;
	typedef enum logic [1:0] {PDG_MODE_POS, PDG_MODE_SPD, PDG_MODE_TRQ, PDG_MODE_RSV} pdg_mode_t;
	typedef enum logic [1:0] {PDG_ST_OFF, PDG_ST_RECOVER, PDG_ST_RUN} pdg_state_t;
endpackage : pdg_pkg

// File: pdg_pct_cmp.sv
// percentage threshold compare: mag > limit * pct / 100, one cycle latency
// assumes mag and limit are unsigned and in the same clock domain
`timescale 1ns/10ps
`include "pdg_defs.svh"
module pdg_pct_cmp #(
	parameter int MAG_W = 32,
	parameter int LIM_W = 30,
	parameter int PCT_W = 7
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [MAG_W-1:0] mag,
	input  wire logic [LIM_W-1:0] limit,
	input  wire logic [PCT_W-1:0] pct,
	output logic                  over_q
);
	localparam int PW = MAG_W + PCT_W + 1;

	// scaling both sides avoids a divider and its rounding
	logic [PW-1:0] lhs;
	logic [PW-1:0] rhs;

	assign lhs = PW'(mag) * PW'(`PDG_PCT_SCALE);
	assign rhs = PW'(limit) * PW'(pct);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			over_q <= 1'b0;
		end else begin
			over_q <= lhs > rhs;
		end
	end
endmodule : pdg_pct_cmp

// File: pdg_guard.sv
// position deviation guard: deviation checks, servo-on recovery with speed clamp, torque clamp, APB registers
// assumes pos_ref, pos_act, speed_cmd and torque_cmd come from logic on clk; servo_on_pin is asynchronous
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "pdg_defs.svh"
module pdg_guard (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic signed [31:0] pos_ref,
	input  wire logic signed [31:0] pos_act,
	input  wire logic               servo_on_pin,
	input  wire logic signed [15:0] speed_cmd,
	input  wire logic signed [15:0] torque_cmd,
	output logic signed [31:0]      deviation,
	output logic signed [15:0]      speed_out,
	output logic signed [15:0]      torque_out,
	output logic                    motor_enable,
	output logic                    irq
);
	////////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchroniser
	logic rst_s1_q, rst_n;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	logic son_s1_q, son_s2_q, son_s3_q, son_lvl_q, son_prev_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			son_s1_q   <= 1'b0;
			son_s2_q   <= 1'b0;
			son_s3_q   <= 1'b0;
			son_lvl_q  <= 1'b0;
			son_prev_q <= 1'b0;
		end else begin
			son_s1_q   <= servo_on_pin;
			son_s2_q   <= son_s1_q;
			son_s3_q   <= son_s2_q;
			if (son_s2_q == son_s3_q) begin
				son_lvl_q <= son_s3_q;
			end
			son_prev_q <= son_lvl_q;
		end
	end
	logic son_rise;
	assign son_rise = son_lvl_q & ~son_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	function automatic logic [29:0] clamp_lim(input logic [31:0] v);
		if (v < 32'(`PDG_LIM_MIN)) begin
			return `PDG_LIM_MIN;
		end else if (v > 32'(`PDG_LIM_MAX)) begin
			return `PDG_LIM_MAX;
		end
		return v[29:0];
	endfunction : clamp_lim

	function automatic logic [6:0] clamp_pct(input logic [31:0] v);
		if (v < 32'(`PDG_PCT_MIN)) begin
			return `PDG_PCT_MIN;
		end else if (v > 32'(`PDG_PCT_MAX)) begin
			return `PDG_PCT_MAX;
		end
		return v[6:0];
	endfunction : clamp_pct

	////////////////////////////////////////////////////////////////////////////////
	// registers
	pdg_pkg::pdg_mode_t  mode_q;
	pdg_pkg::pdg_state_t state_q;
	logic [29:0] ovf_lim_q, son_lim_q;
	logic [6:0]  warn_pct_q, son_pct_q;
	logic [13:0] son_spd_q;
	logic [15:0] trq_max_q;
	logic [`PDG_STS_W-1:0] sts_q, mask_q, sts_set;
	logic [31:0] dev_mag_q;

	logic wr_en, rd_setup, mapped;
	assign pready   = 1'b1;
	assign wr_en    = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign mapped   = paddr <= `PDG_OFF_STATE && paddr[1:0] == 2'h0;
	assign pslverr  = psel & penable & ~mapped;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q     <= pdg_pkg::PDG_MODE_POS;
			ovf_lim_q  <= `PDG_LIM_RST;
			son_lim_q  <= `PDG_LIM_RST;
			warn_pct_q <= `PDG_PCT_RST;
			son_pct_q  <= `PDG_PCT_RST;
			son_spd_q  <= `PDG_SPD_RST;
			trq_max_q  <= `PDG_TRQ_RST;
			mask_q     <= '0;
		end else if (wr_en) begin
			if (hit(paddr, `PDG_OFF_CTRL)) begin
				mode_q <= pdg_pkg::pdg_mode_t'(pwdata[1:0]);
			end
			if (hit(paddr, `PDG_OFF_OVF_LIM)) begin
				ovf_lim_q <= clamp_lim(pwdata);
			end
			if (hit(paddr, `PDG_OFF_SON_LIM)) begin
				son_lim_q <= clamp_lim(pwdata);
			end
			if (hit(paddr, `PDG_OFF_WARN_PCT)) begin
				warn_pct_q <= clamp_pct(pwdata);
			end
			if (hit(paddr, `PDG_OFF_SON_PCT)) begin
				son_pct_q <= clamp_pct(pwdata);
			end
			if (hit(paddr, `PDG_OFF_SON_SPD)) begin
				son_spd_q <= (pwdata > 32'(`PDG_SPD_MAX)) ? `PDG_SPD_MAX : pwdata[13:0];
			end
			if (hit(paddr, `PDG_OFF_TRQ_MAX)) begin
				trq_max_q <= pwdata[15:0];
			end
			if (hit(paddr, `PDG_OFF_MASK)) begin
				mask_q <= pwdata[`PDG_STS_W-1:0];
			end
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sts_q <= '0;
		end else begin
			sts_q <= (sts_q & ~((wr_en && hit(paddr, `PDG_OFF_STATUS)) ? pwdata[`PDG_STS_W-1:0] : '0)) | sts_set;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (rd_setup) begin
			case (paddr)
				`PDG_OFF_CTRL:     prdata <= {30'h0, mode_q};
				`PDG_OFF_OVF_LIM:  prdata <= {2'h0, ovf_lim_q};
				`PDG_OFF_SON_LIM:  prdata <= {2'h0, son_lim_q};
				`PDG_OFF_WARN_PCT: prdata <= {25'h0, warn_pct_q};
				`PDG_OFF_SON_PCT:  prdata <= {25'h0, son_pct_q};
				`PDG_OFF_SON_SPD:  prdata <= {18'h0, son_spd_q};
				`PDG_OFF_TRQ_MAX:  prdata <= {16'h0, trq_max_q};
				`PDG_OFF_STATUS:   prdata <= {27'h0, sts_q};
				`PDG_OFF_MASK:     prdata <= {27'h0, mask_q};
				`PDG_OFF_DEV:      prdata <= deviation;
				`PDG_OFF_STATE:    prdata <= {30'h0, state_q};
				default:           prdata <= '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(sts_d_view() & mask_q);
		end
	end
	function automatic logic [`PDG_STS_W-1:0] sts_d_view();
		return sts_q;
	endfunction : sts_d_view

	////////////////////////////////////////////////////////////////////////////////
	// deviation and threshold checks
	logic        pos_mode, alarm_any, warn_over, son_warn_over;
	logic [31:0] ovf_lim_w, son_lim_w;
	assign pos_mode  = mode_q == pdg_pkg::PDG_MODE_POS;
	assign alarm_any = sts_q[`PDG_STS_OVF] | sts_q[`PDG_STS_SON] | sts_q[`PDG_STS_SON_SPD];
	assign ovf_lim_w = {2'h0, ovf_lim_q};
	assign son_lim_w = {2'h0, son_lim_q};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			deviation <= '0;
			dev_mag_q <= '0;
		end else begin
			deviation <= pos_ref - pos_act;
			// magnitude so that lag either way trips the same checks; -2**31 maps to 2**31
			dev_mag_q <= deviation[31] ? 32'(-deviation) : deviation;
		end
	end

	pdg_pct_cmp u_warn_cmp (
		.clk    (clk),
		.rst_n  (rst_n),
		.mag    (dev_mag_q),
		.limit  (ovf_lim_q),
		.pct    (warn_pct_q),
		.over_q (warn_over)
	);

	pdg_pct_cmp u_son_warn_cmp (
		.clk    (clk),
		.rst_n  (rst_n),
		.mag    (dev_mag_q),
		.limit  (son_lim_q),
		.pct    (son_pct_q),
		.over_q (son_warn_over)
	);

	always_comb begin
		sts_set = '0;
		if (pos_mode) begin
			sts_set[`PDG_STS_OVF]      = state_q == pdg_pkg::PDG_ST_RUN && dev_mag_q > ovf_lim_w;
			sts_set[`PDG_STS_SON_SPD]  = state_q == pdg_pkg::PDG_ST_RECOVER && dev_mag_q > ovf_lim_w;
			sts_set[`PDG_STS_SON]      = state_q == pdg_pkg::PDG_ST_OFF && son_rise && dev_mag_q > son_lim_w;
			sts_set[`PDG_STS_WARN]     = state_q != pdg_pkg::PDG_ST_OFF && warn_over;
			sts_set[`PDG_STS_SON_WARN] = state_q == pdg_pkg::PDG_ST_OFF && son_warn_over;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// servo state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= pdg_pkg::PDG_ST_OFF;
		end else begin
			case (state_q)
				pdg_pkg::PDG_ST_OFF: begin
					// a refused switch-on needs the pin to drop and rise again
					if (son_rise && !alarm_any && !sts_set[`PDG_STS_SON]) begin
						state_q <= (pos_mode && dev_mag_q != '0) ? pdg_pkg::PDG_ST_RECOVER : pdg_pkg::PDG_ST_RUN;
					end
				end
				pdg_pkg::PDG_ST_RECOVER: begin
					if (!son_lvl_q || alarm_any) begin
						state_q <= pdg_pkg::PDG_ST_OFF;
					end else if (dev_mag_q == '0 || !pos_mode) begin
						state_q <= pdg_pkg::PDG_ST_RUN;
					end
				end
				pdg_pkg::PDG_ST_RUN: begin
					if (!son_lvl_q || alarm_any) begin
						state_q <= pdg_pkg::PDG_ST_OFF;
					end
				end
				default: state_q <= pdg_pkg::PDG_ST_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// drive outputs
	logic signed [16:0] spd_lim_s, trq_lim_s, spd_in_s, trq_in_s;
	assign spd_lim_s = {3'h0, son_spd_q};
	assign trq_lim_s = {1'b0, trq_max_q};
	assign spd_in_s  = 17'(speed_cmd);
	assign trq_in_s  = 17'(torque_cmd);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			motor_enable <= 1'b0;
			speed_out    <= '0;
			torque_out   <= '0;
		end else begin
			motor_enable <= state_q != pdg_pkg::PDG_ST_OFF && !alarm_any && son_lvl_q;
			if (state_q == pdg_pkg::PDG_ST_OFF || alarm_any) begin
				speed_out  <= '0;
				torque_out <= '0;
			end else begin
				// the loop closes on deviation, so passing its command returns the motor home
				if (state_q == pdg_pkg::PDG_ST_RECOVER && spd_in_s > spd_lim_s) begin
					speed_out <= 16'(spd_lim_s);
				end else if (state_q == pdg_pkg::PDG_ST_RECOVER && spd_in_s < -spd_lim_s) begin
					speed_out <= 16'(-spd_lim_s);
				end else begin
					speed_out <= speed_cmd;
				end
				if (trq_in_s > trq_lim_s) begin
					torque_out <= 16'(trq_lim_s);
				end else if (trq_in_s < -trq_lim_s) begin
					torque_out <= 16'(-trq_lim_s);
				end else begin
					torque_out <= torque_cmd;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_dev_compute: assert property (##1 deviation == $past(pos_ref) - $past(pos_act))
		else $error("deviation not ref minus actual");
	a_mode_gate: assert property (!pos_mode && !sts_q[`PDG_STS_OVF] && !(wr_en && hit(paddr, `PDG_OFF_CTRL))
		|=> !sts_q[`PDG_STS_OVF])
		else $error("overflow alarm outside position mode");
	a_ovf_alarm: assert property (pos_mode && state_q == pdg_pkg::PDG_ST_RUN && dev_mag_q > ovf_lim_w
		|=> sts_q[`PDG_STS_OVF] ##1 !motor_enable && state_q == pdg_pkg::PDG_ST_OFF)
		else $error("overflow did not alarm and stop");
	a_lim_range: assert property (ovf_lim_q >= `PDG_LIM_MIN && ovf_lim_q <= `PDG_LIM_MAX
		&& son_lim_q >= `PDG_LIM_MIN)
		else $error("limit out of range");
	a_warn_set: assert property (pos_mode && state_q == pdg_pkg::PDG_ST_RUN
		&& 39'(dev_mag_q) * 39'(`PDG_PCT_SCALE) > 39'(ovf_lim_q) * 39'(warn_pct_q)
		&& $stable(ovf_lim_q) && $stable(warn_pct_q) ##1 pos_mode && state_q != pdg_pkg::PDG_ST_OFF
		|=> sts_q[`PDG_STS_WARN])
		else $error("warning not raised");
	a_son_refuse: assert property (pos_mode && state_q == pdg_pkg::PDG_ST_OFF && son_rise && dev_mag_q > son_lim_w
		|=> sts_q[`PDG_STS_SON] && state_q == pdg_pkg::PDG_ST_OFF)
		else $error("servo-on with deviation not refused");
	a_recover_clamp: assert property (state_q == pdg_pkg::PDG_ST_RECOVER && !alarm_any
		|=> speed_out <= 16'(spd_lim_s) && speed_out >= 16'(-spd_lim_s))
		else $error("speed not clamped on recovery");
	a_recover_alarm: assert property (pos_mode && state_q == pdg_pkg::PDG_ST_RECOVER && dev_mag_q > ovf_lim_w
		|=> sts_q[`PDG_STS_SON_SPD] && !sts_q[`PDG_STS_OVF] || $past(sts_q[`PDG_STS_OVF]))
		else $error("recovery overflow alarm wrong");
	a_spd_range: assert property (son_spd_q <= `PDG_SPD_MAX && son_pct_q >= `PDG_PCT_MIN
		&& son_pct_q <= `PDG_PCT_MAX)
		else $error("speed or percent out of range");
	a_trq_clamp: assert property (##1 17'(torque_out) <= $past(trq_lim_s) && 17'(torque_out) >= -$past(trq_lim_s))
		else $error("torque above maximum");
	a_mag_sign: assert property (##1 dev_mag_q == ($past(deviation[31]) ? 32'(-$past(deviation)) : $past(deviation)))
		else $error("magnitude wrong");
	a_recover_exit: assert property (state_q == pdg_pkg::PDG_ST_RECOVER && son_lvl_q && !alarm_any
		&& dev_mag_q == '0 |=> state_q == pdg_pkg::PDG_ST_RUN)
		else $error("recovery did not end at zero");
endmodule : pdg_guard

// File: pdg_host_model.sv
// host motion controller model: drives position reference and actual position
// assumes the bench sets both through put() just after a rising edge
`timescale 1ns/10ps
module pdg_host_model (
	input  wire logic          clk,
	output logic signed [31:0] pos_ref,
	output logic signed [31:0] pos_act
);
	logic follow;

	initial begin
		pos_ref = '0;
		pos_act = '0;
		follow = 1'b0;
	end

	task automatic put(input logic signed [31:0] r, input logic signed [31:0] a);
		pos_ref <= r;
		pos_act <= a;
	endtask : put

	////////////////////////////////////////////////////////////////////////////
	// one count per clock: slow follower so recovery is seen as a state
	always @(posedge clk) begin
		if (follow && pos_act < pos_ref) begin
			pos_act <= pos_act + 32'sd1;
		end else if (follow && pos_act > pos_ref) begin
			pos_act <= pos_act - 32'sd1;
		end
	end
endmodule : pdg_host_model

// File: pdg_guard_tb_top.sv
// self-checking bench of the deviation guard: apb tasks and directed tests
// assumes pdg_defs.svh offsets and the state encoding 0 off, 1 recover, 2 run
`timescale 1ns/10ps
`include "pdg_defs.svh"
module pdg_guard_tb_top;
	logic               clk;
	logic               nrst;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic signed [31:0] pos_ref;
	logic signed [31:0] pos_act;
	logic               servo_on_pin;
	logic signed [15:0] speed_cmd;
	logic signed [15:0] torque_cmd;
	logic signed [31:0] deviation;
	logic signed [15:0] speed_out;
	logic signed [15:0] torque_out;
	logic               motor_enable;
	logic               irq;
	logic [31:0]        rv;
	logic               rerr;
	int                 miscompares;
	int                 num_checks;

	pdg_guard u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pos_ref(pos_ref), .pos_act(pos_act), .servo_on_pin(servo_on_pin), .speed_cmd(speed_cmd),
		.torque_cmd(torque_cmd), .deviation(deviation), .speed_out(speed_out),
		.torque_out(torque_out), .motor_enable(motor_enable), .irq(irq));
	pdg_host_model u_host (.clk(clk), .pos_ref(pos_ref), .pos_act(pos_act));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// hold the request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			miscompares++;
			tally_and_finish();
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rv, exp);
	endtask : rc

	task automatic son(input logic v);
		@(posedge clk);
		servo_on_pin <= v;
		cyc(8);
	endtask : son

	task automatic dev(input logic signed [31:0] r, input logic signed [31:0] a);
		@(posedge clk);
		u_host.put(r, a);
		cyc(7);
	endtask : dev

	////////////////////////////////////////////////////////////////////////////
	logic [7:0]  ra [11] = '{`PDG_OFF_CTRL, `PDG_OFF_OVF_LIM, `PDG_OFF_SON_LIM, `PDG_OFF_WARN_PCT,
		`PDG_OFF_SON_PCT, `PDG_OFF_SON_SPD, `PDG_OFF_TRQ_MAX, `PDG_OFF_STATUS, `PDG_OFF_MASK,
		`PDG_OFF_DEV, `PDG_OFF_STATE};
	logic [31:0] rx [11] = '{32'h0, 32'h02800000, 32'h02800000, 32'h64, 32'h64, 32'h2710,
		32'h7fff, 32'h0, 32'h0, 32'h0, 32'h0};

	initial begin
		int n;
		miscompares = 0;
		num_checks = 0;
		nrst = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		servo_on_pin = 1'b0;
		speed_cmd = '0;
		torque_cmd = '0;
		cyc(12);
		nrst <= 1'b1;
		cyc(3);
		for (int i = 0; i < 11; i++) rc(ra[i], rx[i]);
		rc(8'h2c, 32'h0);
		chk(rerr, 1'b1);
		$display("test reset values done");
		wr(`PDG_OFF_OVF_LIM, 32'h0);
		rc(`PDG_OFF_OVF_LIM, 32'h1);
		wr(`PDG_OFF_OVF_LIM, 32'h40000000);
		rc(`PDG_OFF_OVF_LIM, 32'h3fffffff);
		wr(`PDG_OFF_SON_PCT, 32'h5);
		rc(`PDG_OFF_SON_PCT, 32'ha);
		wr(`PDG_OFF_SON_SPD, 32'h4e20);
		rc(`PDG_OFF_SON_SPD, 32'h2710);
		$display("test range clamps done");
		wr(`PDG_OFF_OVF_LIM, 32'h3e8);
		wr(`PDG_OFF_SON_LIM, 32'h3e8);
		wr(`PDG_OFF_WARN_PCT, 32'h32);
		wr(`PDG_OFF_SON_PCT, 32'h64);
		wr(`PDG_OFF_TRQ_MAX, 32'h64);
		wr(`PDG_OFF_MASK, 32'h1f);
		son(1'b1);
		rc(`PDG_OFF_STATE, 32'h2);
		chk(motor_enable, 1'b1);
		torque_cmd <= 16'sd500;
		cyc(3);
		chk(torque_out, 16'h0064);
		torque_cmd <= -16'sd500;
		cyc(3);
		chk(torque_out, 32'hffffff9c);
		$display("test run and torque done");
		dev(500, 0);
		chk(deviation, 32'h1f4);
		rc(`PDG_OFF_STATUS, 32'h0);
		dev(501, 0);
		rc(`PDG_OFF_STATUS, 32'h8);
		chk(irq, 1'b1);
		wr(`PDG_OFF_MASK, 32'h1);
		cyc(2);
		chk(irq, 1'b0);
		dev(0, 1001);
		chk(deviation, 32'hfffffc17);
		rc(`PDG_OFF_STATUS, 32'h19);
		chk({irq, motor_enable, torque_out}, {2'b10, 16'h0});
		dev(0, 0);
		wr(`PDG_OFF_STATUS, 32'h1f);
		cyc(2);
		rc(`PDG_OFF_STATUS, 32'h0);
		chk(irq, 1'b0);
		$display("test warning and overflow done");
		wr(`PDG_OFF_CTRL, 32'h1);
		son(1'b0);
		son(1'b1);
		dev(0, 5000);
		rc(`PDG_OFF_STATUS, 32'h0);
		chk(motor_enable, 1'b1);
		dev(0, 0);
		wr(`PDG_OFF_CTRL, 32'h0);
		$display("test speed mode done");
		wr(`PDG_OFF_OVF_LIM, 32'h1388);
		son(1'b0);
		dev(2000, 0);
		rc(`PDG_OFF_STATUS, 32'h10);
		son(1'b1);
		rc(`PDG_OFF_STATUS, 32'h12);
		rc(`PDG_OFF_STATE, 32'h0);
		$display("test switch-on refusal done");
		son(1'b0);
		dev(500, 0);
		wr(`PDG_OFF_STATUS, 32'h1f);
		wr(`PDG_OFF_SON_SPD, 32'hc8);
		son(1'b1);
		rc(`PDG_OFF_STATE, 32'h1);
		speed_cmd <= 16'sd300;
		cyc(3);
		chk(speed_out, 16'h00c8);
		speed_cmd <= -16'sd300;
		cyc(3);
		chk(speed_out, 32'hffffff38);
		u_host.follow <= 1'b1;
		for (n = 0; n < 2000 && deviation !== 32'sd0; n++) @(posedge clk);
		// a follower that never closes the gap is a failure, not a hang
		if (n >= 2000) begin
			miscompares++;
			tally_and_finish();
		end
		cyc(4);
		rc(`PDG_OFF_STATE, 32'h2);
		u_host.follow <= 1'b0;
		son(1'b0);
		dev(800, 0);
		son(1'b1);
		dev(6000, 0);
		// warning is raised while still recovering, servo-on warning once back off
		rc(`PDG_OFF_STATUS, 32'h1c);
		chk(rv & 32'h7, 32'h4);
		chk(motor_enable, 1'b0);
		$display("test recovery done");
		tally_and_finish();
	end
endmodule : pdg_guard_tb_top
